// file: common/tlfc_defs.svh
`ifndef TLFC_DEFS_SVH
`define TLFC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TLFC_OFS_AMB_STEP_DLY  8'hb5
`define TLFC_OFS_REM_DLY       8'hb6
`define TLFC_OFS_LOWER_EN      8'hb7
`define TLFC_OFS_TOP_STS       8'hb8
`define TLFC_OFS_RSVD_BA       8'hba
`define TLFC_OFS_RSVD_BB       8'hbb
`define TLFC_OFS_RSVD_BD       8'hbd
`define TLFC_OFS_RSVD_BF       8'hbf
`define TLFC_OFS_RSVD_C0       8'hc0
`define TLFC_OFS_TRIP_CTRL     8'hc1
`define TLFC_OFS_TRIP_LIM_R1   8'hc4
`define TLFC_OFS_TRIP_LIM_R2   8'hc5
`define TLFC_OFS_TRIP_LIM_AMB  8'hc9
`define TLFC_OFS_TRIP_STS      8'hca
`define TLFC_OFS_TRIP_OE       8'hcb
`define TLFC_OFS_ZONE_IRQ_EN   8'hce
`define TLFC_OFS_FAN1_MAX      8'hd1
`define TLFC_OFS_FAN2_MAX      8'hd6
`define TLFC_OFS_FAN3_MAX      8'hdb
`define TLFC_OFS_RES_SEL       8'he0

// ****************************************
// Reset values
// ****************************************
`define TLFC_RST_ZERO          8'h00
`define TLFC_RST_RSVD_BA       8'h03
`define TLFC_RST_TRIP_CTRL     8'h01
`define TLFC_RST_TRIP_LIM      8'h7f
`define TLFC_RST_FAN_MAX       8'hff

// ****************************************
// Field positions
// ****************************************
`define TLFC_AMB_STEP_MSB      5
`define TLFC_AMB_STEP_LSB      4
`define TLFC_AMB_DLY_MSB       1
`define TLFC_AMB_DLY_LSB       0
`define TLFC_R1_DLY_MSB        7
`define TLFC_R1_DLY_LSB        6
`define TLFC_R2_DLY_MSB        5
`define TLFC_R2_DLY_LSB        4
`define TLFC_TOP_INT_EN_BIT    0
`define TLFC_TRIP_CTRL_BIT     1

// ****************************************
// Timing
// ****************************************
`define TLFC_CLK_MHZ           100
`define TLFC_MINUTE_S          60
`define TLFC_MINUTE_CYCLES     (64'(`TLFC_MINUTE_S) * 64'(`TLFC_CLK_MHZ) * 64'd1000000)

`endif

// file: common/tlfc_pkg.sv
`default_nettype none
package tlfc_pkg;
  typedef logic [7:0] tlfc_byte_t;
  // Zone order in all 3-bit vectors: [2]=remote2, [1]=remote1, [0]=ambient
  typedef logic [2:0] tlfc_zones_t;
  typedef enum logic [1:0] {
    TLFC_IDLE = 2'b01,
    TLFC_WAIT = 2'b10
  } tlfc_lower_state_t;
endpackage
`default_nettype wire

// file: logic/tlfc_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tlfc_defs.svh"

// Overview of operation
// - Lock freezes every configuration register; status clears bypass it
// - Ambient step bits 5:4, delay 1:0
// - Step code 00..11 subtracts 2..8 degrees
// - Delay code 00..11 waits 1..4 minutes
// - Lower low limit when above top, enabled
// - Enable bits 3:1 are remote2, remote1, ambient
// - Top value still sets top flags when lowering disabled
// - Bit 0 gates top flags onto interrupt
// - Top flags set when reading exceeds top
// - Top flags sticky, cleared by writing one
// - Clear only if zone no longer above top
// - Both status registers reset to zero
// - Control bit 1 gates trip output
// - Separate trip limits per zone, reset 7Fh
// - Trip flag set when above trip limit
// - Two successive cycles over limit needed
// - Per-zone trip output enables, reset off
// - Trip flags clear only when pin inactive
// - Three max duty registers, reset FFh
// - Two-bit resolution select per fan
// - Minimum limit accepts -127 to +127
module tlfc_regs #(
  parameter longint unsigned MinuteCycles = `TLFC_MINUTE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [7:0]  regRdData,
  input  wire logic        lockBit,
  input  wire logic        globalIrqEnable,
  input  wire logic        monitorCycleDone,
  input  wire logic [23:0] zoneTempReading,
  input  wire logic [23:0] zoneTopTemp,
  input  wire logic [23:0] zoneLowLimitIn,
  output logic      [2:0]  lowLimitLoad,
  output logic      [23:0] lowLimitLowered,
  output logic      [7:0]  fan1MaxDuty,
  output logic      [7:0]  fan2MaxDuty,
  output logic      [7:0]  fan3MaxDuty,
  output logic      [5:0]  fanResolutionSel,
  output logic             overtempTripOutN,
  output logic             monitorIrqOutN
);

  // ****************************************
  // Register storage
  // ****************************************
  tlfc_pkg::tlfc_byte_t  ambStepDly_ff;
  tlfc_pkg::tlfc_byte_t  remDly_ff;
  tlfc_pkg::tlfc_byte_t  lowerEn_ff;
  tlfc_pkg::tlfc_zones_t topSts_ff;
  tlfc_pkg::tlfc_byte_t  rsvdBa_ff;
  tlfc_pkg::tlfc_byte_t  rsvdBf_ff;
  tlfc_pkg::tlfc_byte_t  rsvdC0_ff;
  tlfc_pkg::tlfc_byte_t  tripCtrl_ff;
  tlfc_pkg::tlfc_byte_t  tripLim_ff [3];
  tlfc_pkg::tlfc_zones_t tripSts_ff;
  tlfc_pkg::tlfc_zones_t tripOe_ff;
  tlfc_pkg::tlfc_zones_t zoneIrqEn_ff;
  tlfc_pkg::tlfc_byte_t  fanMax_ff [3];
  logic [5:0]            resSel_ff;
  tlfc_pkg::tlfc_zones_t tripOver_ff;
  logic [7:0]            rdData_ff;

  logic                  wrOk;
  tlfc_pkg::tlfc_zones_t aboveTop;
  tlfc_pkg::tlfc_zones_t aboveTrip;
  tlfc_pkg::tlfc_zones_t lowerGo;
  logic [1:0]            zoneStep [3];
  logic [1:0]            zoneDly [3];
  logic                  tripActive;
  logic                  topClr;
  logic                  tripClr;

  // ****************************************
  // Write qualification
  // ****************************************
  // Status clears bypass the lock; only configuration freezes
  assign wrOk    = regWrStb & ~lockBit;
  assign topClr  = regWrStb && regAddr == `TLFC_OFS_TOP_STS;
  // Clearing while the pin is low is refused whole, so the pin cannot glitch
  assign tripClr = regWrStb && regAddr == `TLFC_OFS_TRIP_STS && !tripActive;

  // ****************************************
  // Zone field selection
  // ****************************************
  // Zone fields: index 0 ambient, 1 remote1, 2 remote2
  assign zoneStep[0] = ambStepDly_ff[`TLFC_AMB_STEP_MSB:`TLFC_AMB_STEP_LSB];
  assign zoneStep[1] = 2'h0;
  assign zoneStep[2] = 2'h0;
  assign zoneDly[0]  = ambStepDly_ff[`TLFC_AMB_DLY_MSB:`TLFC_AMB_DLY_LSB];
  assign zoneDly[1]  = remDly_ff[`TLFC_R1_DLY_MSB:`TLFC_R1_DLY_LSB];
  assign zoneDly[2]  = remDly_ff[`TLFC_R2_DLY_MSB:`TLFC_R2_DLY_LSB];

  // ****************************************
  // Writable registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      ambStepDly_ff <= `TLFC_RST_ZERO;
      remDly_ff     <= `TLFC_RST_ZERO;
      lowerEn_ff    <= `TLFC_RST_ZERO;
      rsvdBa_ff     <= `TLFC_RST_RSVD_BA;
      rsvdBf_ff     <= `TLFC_RST_ZERO;
      rsvdC0_ff     <= `TLFC_RST_ZERO;
      tripCtrl_ff   <= `TLFC_RST_TRIP_CTRL;
      tripLim_ff[0] <= `TLFC_RST_TRIP_LIM;
      tripLim_ff[1] <= `TLFC_RST_TRIP_LIM;
      tripLim_ff[2] <= `TLFC_RST_TRIP_LIM;
      tripOe_ff     <= 3'h0;
      zoneIrqEn_ff  <= 3'h0;
      fanMax_ff[0]  <= `TLFC_RST_FAN_MAX;
      fanMax_ff[1]  <= `TLFC_RST_FAN_MAX;
      fanMax_ff[2]  <= `TLFC_RST_FAN_MAX;
      resSel_ff     <= 6'h00;
    end else if (wrOk) begin
      unique case (regAddr)
        `TLFC_OFS_AMB_STEP_DLY: ambStepDly_ff <= regWrData & 8'h33;
        `TLFC_OFS_REM_DLY:      remDly_ff     <= regWrData & 8'hf0;
        `TLFC_OFS_LOWER_EN:     lowerEn_ff    <= regWrData & 8'h0f;
        // Reserved bytes BA, BF and C0 are plain storage; software keeps the defaults
        `TLFC_OFS_RSVD_BA:      rsvdBa_ff     <= regWrData;
        `TLFC_OFS_RSVD_BF:      rsvdBf_ff     <= regWrData;
        `TLFC_OFS_RSVD_C0:      rsvdC0_ff     <= regWrData;
        `TLFC_OFS_TRIP_CTRL:    tripCtrl_ff   <= regWrData;
        `TLFC_OFS_TRIP_LIM_AMB: tripLim_ff[0] <= regWrData;
        `TLFC_OFS_TRIP_LIM_R1:  tripLim_ff[1] <= regWrData;
        `TLFC_OFS_TRIP_LIM_R2:  tripLim_ff[2] <= regWrData;
        `TLFC_OFS_TRIP_OE:      tripOe_ff     <= regWrData[2:0];
        `TLFC_OFS_ZONE_IRQ_EN:  zoneIrqEn_ff  <= regWrData[2:0];
        `TLFC_OFS_FAN1_MAX:     fanMax_ff[0]  <= regWrData;
        `TLFC_OFS_FAN2_MAX:     fanMax_ff[1]  <= regWrData;
        `TLFC_OFS_FAN3_MAX:     fanMax_ff[2]  <= regWrData;
        `TLFC_OFS_RES_SEL:      resSel_ff     <= regWrData[5:0];
        // Read-only and unmapped offsets drop the write
        default: ;
      endcase
    end
  end

  // ****************************************
  // Per-zone comparisons and lowering
  // ****************************************
  // Remote step fields live in the neighbouring register outside this bank,
  // so the remote zones use the default 2 degree step here.
  genvar z;
  generate
    for (z = 0; z < 3; z++) begin : g_zone
      tlfc_pkg::tlfc_lower_state_t state_ff;
      // Four minutes at full clock rate needs more than 32 bits
      logic [39:0]                 waitCnt_ff;
      tlfc_pkg::tlfc_byte_t        loweredLim_ff;
      logic [7:0]                  stepDeg;
      logic [7:0]                  lowIn;
      logic [7:0]                  lowNext;
      logic [39:0]                 waitLen;

      // Signed readings so the full -127..+127 minimum span compares right
      assign aboveTop[z]  = $signed(zoneTempReading[z*8 +: 8]) > $signed(zoneTopTemp[z*8 +: 8]);
      assign aboveTrip[z] = $signed(zoneTempReading[z*8 +: 8]) > $signed(tripLim_ff[z]);
      assign stepDeg      = {5'h00, zoneStep[z], 1'b0} + 8'h02;
      assign lowIn        = zoneLowLimitIn[z*8 +: 8];
      // Stop at -127 rather than wrapping to a huge positive limit
      assign lowNext      = ($signed(lowIn) - $signed(stepDeg) < -9'sd127) ? 8'h81
                            : 8'(lowIn - stepDeg);
      assign waitLen      = 40'(MinuteCycles) * (40'(zoneDly[z]) + 40'h1);
      // Idle-only start: a zone waits out its delay before lowering again
      assign lowerGo[z]   = (state_ff == tlfc_pkg::TLFC_IDLE) & lowerEn_ff[z+1] & aboveTop[z];

      always_ff @(posedge clock) begin
        if (rst) begin
          state_ff   <= tlfc_pkg::TLFC_IDLE;
          waitCnt_ff <= 40'h0;
        end else begin
          unique case (state_ff)
            tlfc_pkg::TLFC_IDLE: begin
              if (lowerGo[z]) begin
                state_ff   <= tlfc_pkg::TLFC_WAIT;
                waitCnt_ff <= waitLen - 40'h1;
              end
            end
            tlfc_pkg::TLFC_WAIT: begin
              if (waitCnt_ff == 40'h0) begin
                state_ff <= tlfc_pkg::TLFC_IDLE;
              end else begin
                waitCnt_ff <= waitCnt_ff - 40'h1;
              end
            end
            default: state_ff <= tlfc_pkg::TLFC_IDLE;
          endcase
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          loweredLim_ff <= 8'h00;
        end else if (lowerGo[z]) begin
          loweredLim_ff <= lowNext;
        end
      end

      assign lowLimitLowered[z*8 +: 8] = loweredLim_ff;
    end
  endgenerate

  // ****************************************
  // Lowering load strobe
  // ****************************************
  // Registered so the strobe lines up with the new limit value

  always_ff @(posedge clock) begin
    if (rst) begin
      lowLimitLoad <= 3'h0;
    end else begin
      lowLimitLoad <= lowerGo;
    end
  end

  // ****************************************
  // Top-temperature status
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      topSts_ff <= 3'h0;
    end else begin
      if (topClr) begin
        // Set wins; clear only when the zone has cooled
        topSts_ff <= (topSts_ff & ~(regWrData[2:0] & ~aboveTop)) | aboveTop;
      end else begin
        topSts_ff <= topSts_ff | aboveTop;
      end
    end
  end

  // ****************************************
  // Interrupt gating
  // ****************************************
  // Registered so a status write cannot glitch the pin
  always_ff @(posedge clock) begin
    if (rst) begin
      monitorIrqOutN <= 1'b1;
    end else begin
      monitorIrqOutN <= ~(lowerEn_ff[`TLFC_TOP_INT_EN_BIT] & globalIrqEnable & (|topSts_ff));
    end
  end

  // ****************************************
  // Trip path
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      tripOver_ff <= 3'h0;
    end else if (monitorCycleDone) begin
      tripOver_ff <= aboveTrip;
    end
  end

  // Pin follows the sticky status, so it stays low until software drops the trip output enable or control bit 1
  assign tripActive = tripCtrl_ff[`TLFC_TRIP_CTRL_BIT] & (|(tripSts_ff & tripOe_ff));

  always_ff @(posedge clock) begin
    if (rst) begin
      tripSts_ff <= 3'h0;
    end else begin
      if (tripClr) begin
        // Set wins over a clear in the same cycle
        tripSts_ff <= (tripSts_ff & ~regWrData[2:0])
                      | ({3{monitorCycleDone}} & tripOver_ff & aboveTrip);
      end else if (monitorCycleDone) begin
        tripSts_ff <= tripSts_ff | (tripOver_ff & aboveTrip);
      end
    end
  end

  // ****************************************
  // Trip pin
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      overtempTripOutN <= 1'b1;
    end else begin
      overtempTripOutN <= ~tripActive;
    end
  end

  // ****************************************
  // Outputs and read port
  // ****************************************
  assign fan1MaxDuty      = fanMax_ff[0];
  assign fan2MaxDuty      = fanMax_ff[1];
  assign fan3MaxDuty      = fanMax_ff[2];
  assign fanResolutionSel = resSel_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else if (regRdStb) begin
      unique case (regAddr)
        `TLFC_OFS_AMB_STEP_DLY: rdData_ff <= ambStepDly_ff;
        `TLFC_OFS_REM_DLY:      rdData_ff <= remDly_ff;
        `TLFC_OFS_LOWER_EN:     rdData_ff <= lowerEn_ff;
        `TLFC_OFS_TOP_STS:      rdData_ff <= {5'h00, topSts_ff};
        `TLFC_OFS_RSVD_BA:      rdData_ff <= rsvdBa_ff;
        `TLFC_OFS_RSVD_BF:      rdData_ff <= rsvdBf_ff;
        `TLFC_OFS_RSVD_C0:      rdData_ff <= rsvdC0_ff;
        `TLFC_OFS_TRIP_CTRL:    rdData_ff <= tripCtrl_ff;
        `TLFC_OFS_TRIP_LIM_AMB: rdData_ff <= tripLim_ff[0];
        `TLFC_OFS_TRIP_LIM_R1:  rdData_ff <= tripLim_ff[1];
        `TLFC_OFS_TRIP_LIM_R2:  rdData_ff <= tripLim_ff[2];
        `TLFC_OFS_TRIP_STS:     rdData_ff <= {5'h00, tripSts_ff};
        `TLFC_OFS_TRIP_OE:      rdData_ff <= {5'h00, tripOe_ff};
        `TLFC_OFS_ZONE_IRQ_EN:  rdData_ff <= {5'h00, zoneIrqEn_ff};
        `TLFC_OFS_FAN1_MAX:     rdData_ff <= fanMax_ff[0];
        `TLFC_OFS_FAN2_MAX:     rdData_ff <= fanMax_ff[1];
        `TLFC_OFS_FAN3_MAX:     rdData_ff <= fanMax_ff[2];
        `TLFC_OFS_RES_SEL:      rdData_ff <= {2'h0, resSel_ff};
        default:                rdData_ff <= 8'h00;
      endcase
    end else begin
      // Idle port reads zero so a late sample never sees stale data
      rdData_ff <= 8'h00;
    end
  end

  assign regRdData = rdData_ff;

endmodule // tlfc_regs

`default_nettype wire

// file: test/tlfc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checks
// ****************************************
module tlfc_regs_checker #(
  parameter longint unsigned MinuteCycles = 20
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        regRdStb,
  input wire logic [7:0]  regRdData,
  input wire logic        lockBit,
  input wire logic        globalIrqEnable,
  input wire logic        monitorCycleDone,
  input wire logic [23:0] zoneTempReading,
  input wire logic [23:0] zoneTopTemp,
  input wire logic [23:0] zoneLowLimitIn,
  input wire logic [2:0]  lowLimitLoad,
  input wire logic [23:0] lowLimitLowered,
  input wire logic [7:0]  fan1MaxDuty,
  input wire logic [5:0]  fanResolutionSel,
  input wire logic        overtempTripOutN,
  input wire logic        monitorIrqOutN
);
  // Saturating count of monitor pulses; trip needs two
  logic [1:0] pulseCnt_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      pulseCnt_ff <= 2'h0;
    end else if (monitorCycleDone && pulseCnt_ff != 2'h3) begin
      pulseCnt_ff <= pulseCnt_ff + 2'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property ($fell(rst) |-> overtempTripOutN && monitorIrqOutN && lowLimitLoad == 3'h0)
    else $error("outputs not idle after reset");
  AST_RD_QUIET: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  AST_LOAD_SPACING: assert property (lowLimitLoad[0] |=> !lowLimitLoad[0] [*8])
    else $error("lowering repeated too soon");
  AST_LOAD_CAUSE: assert property (lowLimitLoad[0] |-> $signed($past(zoneTempReading[7:0])) > $signed($past(zoneTopTemp[7:0])))
    else $error("lowering without exceeding top");
  AST_LOAD_STEP: assert property (lowLimitLoad[0] |-> lowLimitLowered[7:0] == 8'h81 ||
    ((int'($signed($past(zoneLowLimitIn[7:0]))) - int'($signed(lowLimitLowered[7:0]))) inside {2, 4, 6, 8}))
    else $error("lowering amount wrong");
  AST_TRIP_QUAL: assert property (!overtempTripOutN |-> pulseCnt_ff >= 2'h2)
    else $error("trip before two monitor cycles");
  AST_IRQ_GLOBAL: assert property (!monitorIrqOutN |-> $past(globalIrqEnable))
    else $error("irq without global enable");
  AST_LOCK_HOLD: assert property (lockBit |=> $stable(fan1MaxDuty) && $stable(fanResolutionSel))
    else $error("locked register changed");
endmodule // tlfc_regs_checker
`default_nettype wire

// file: test/tlfc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tlfc_regs_tb;
  localparam int unsigned MinCyc = 20;
  logic        clock = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
  logic        lockBit = 1'b0, globalIrqEnable = 1'b0, monitorCycleDone = 1'b0;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, fan1MaxDuty, fan2MaxDuty, fan3MaxDuty;
  logic [23:0] zoneTempReading = 24'h101010, zoneTopTemp = 24'h2d2d2d, zoneLowLimitIn = 24'h202020;
  logic [23:0] lowLimitLowered;
  logic [2:0]  lowLimitLoad;
  logic [5:0]  fanResolutionSel;
  logic        overtempTripOutN, monitorIrqOutN;
  int          num_errors = 0, checked = 0, n;
  logic [7:0]  rA [12] = '{8'hc1, 8'hc4, 8'hc5, 8'hc9, 8'hca, 8'hb8, 8'hcb, 8'hd1, 8'hd6, 8'hdb, 8'hba, 8'he0};
  logic [7:0]  rE [12] = '{8'h01, 8'h7f, 8'h7f, 8'h7f, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00};

  tlfc_regs #(.MinuteCycles(MinCyc)) dut (.clock, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .lockBit, .globalIrqEnable, .monitorCycleDone, .zoneTempReading, .zoneTopTemp,
    .zoneLowLimitIn, .lowLimitLoad, .lowLimitLowered, .fan1MaxDuty, .fan2MaxDuty, .fan3MaxDuty,
    .fanResolutionSel, .overtempTripOutN, .monitorIrqOutN);

  always #5 clock = ~clock;

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task chk(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  // Data is only valid in the slot after the strobe
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1;
    chk(e, regRdData);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task rdg(input logic [23:0] v);
    @(posedge clock);
    zoneTempReading <= v;
  endtask
  task pulse;
    @(posedge clock);
    monitorCycleDone <= 1'b1;
    @(posedge clock);
    monitorCycleDone <= 1'b0;
  endtask
  // Bounded wait for an ambient lowering pulse; n hits 60 if none
  task waitLd;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (lowLimitLoad[0] !== 1'b1 && n < 60);
  endtask
  task wrap_up;
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    foreach (rA[i]) rdc(rA[i], rE[i]);
    chk(8'hff, fan3MaxDuty);
    chk(8'hff, fan1MaxDuty);
    chk({7'h00, overtempTripOutN}, 8'h01);
  endtask
  task t_regs;
    wr(8'hd6, 8'h3c);
    wr(8'he0, 8'hff);
    rdc(8'hd6, 8'h3c);
    chk(8'h3c, fan2MaxDuty);
    rdc(8'he0, 8'h3f);
    wr(8'hba, 8'h03);
    rdc(8'hba, 8'h03);
    chk({2'b00, fanResolutionSel}, 8'h3f);
    wr(8'hbb, 8'h55);
    rdc(8'hbb, 8'h00);
    rdc(8'h50, 8'h00);
    @(posedge clock);
    lockBit <= 1'b1;
    wr(8'hd6, 8'hc3);
    wr(8'he0, 8'h00);
    wr(8'hc4, 8'h00);
    rdc(8'hd6, 8'h3c);
    rdc(8'hc4, 8'h7f);
    chk({2'b00, fanResolutionSel}, 8'h3f);
    @(posedge clock);
    lockBit <= 1'b0;
  endtask
  task t_top;
    rdg(24'h1040f0);
    cyc(3);
    rdc(8'hb8, 8'h02);
    wr(8'hb8, 8'h02);
    rdc(8'hb8, 8'h02);
    wr(8'hb7, 8'h01);
    @(posedge clock);
    globalIrqEnable <= 1'b1;
    cyc(3);
    chk({7'h00, monitorIrqOutN}, 8'h00);
    @(posedge clock);
    globalIrqEnable <= 1'b0;
    cyc(3);
    chk({7'h00, monitorIrqOutN}, 8'h01);
    rdg(24'h101010);
    cyc(2);
    wr(8'hb8, 8'h00);
    rdc(8'hb8, 8'h02);
    wr(8'hb8, 8'h02);
    rdc(8'hb8, 8'h00);
    wr(8'hb7, 8'h00);
  endtask
  task t_trip;
    wr(8'hc5, 8'h20);
    rdg(24'h301010);
    pulse;
    rdg(24'h101010);
    pulse;
    rdg(24'h301010);
    pulse;
    rdc(8'hca, 8'h00);
    pulse;
    rdc(8'hca, 8'h04);
    chk({7'h00, overtempTripOutN}, 8'h01);
    wr(8'hcb, 8'h04);
    cyc(2);
    chk({7'h00, overtempTripOutN}, 8'h01);
    wr(8'hc1, 8'h02);
    cyc(2);
    chk({7'h00, overtempTripOutN}, 8'h00);
    wr(8'hca, 8'h04);
    rdc(8'hca, 8'h04);
    wr(8'hcb, 8'h00);
    cyc(2);
    chk({7'h00, overtempTripOutN}, 8'h01);
    wr(8'hca, 8'h04);
    rdc(8'hca, 8'h00);
  endtask
  task t_lower;
    rdg(24'h101040);
    wr(8'hb7, 8'h04);
    waitLd;
    chk(8'(n), 8'd60);
    for (int s = 0; s < 4; s++) begin
      wr(8'hb5, {2'b00, 2'(s), 4'h0});
      if (s == 0) wr(8'hb7, 8'h02);
      waitLd;
      chk(8'h20 - 8'(2 * (s + 1)), lowLimitLowered[7:0]);
    end
    // Step 2 degrees, delay code 01
    wr(8'hb5, 8'h01);
    rdc(8'hb5, 8'h01);
    waitLd;
    waitLd;
    chk({7'h00, n >= 2 * MinCyc && n <= 2 * MinCyc + 4}, 8'h01);
    wr(8'hb7, 8'h00);
    waitLd;
    chk(8'(n), 8'd60);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_top();
    t_trip();
    t_lower();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
endmodule // tlfc_regs_tb

bind tlfc_regs tlfc_regs_checker #(.MinuteCycles(MinuteCycles)) u_chk (.clock, .rst, .regRdStb, .regRdData,
  .lockBit, .globalIrqEnable, .monitorCycleDone, .zoneTempReading, .zoneTopTemp, .zoneLowLimitIn,
  .lowLimitLoad, .lowLimitLowered, .fan1MaxDuty, .fanResolutionSel, .overtempTripOutN, .monitorIrqOutN);
`default_nettype wire
